// ### inc/mcx_defs.vh
// Functional notes
// - XOR/INCLUSIVE_OR_TO_ACC clear data register before read, combine with A at T3-T4
// - End of execute: P plus one into P and M at T6-T7, back to fetch
// - Subroutine jump: drop read word, write P+1 at T1-T2, M into P at T3
// - Increment-skip: postpone write, increment data at T3-T4, rollover sets carry
// - Increment-skip: delayed write starts at T5, two extra periods inserted
// - Increment-skip: P advances one, plus one more when carry set, at T6-T7
// - Carry clears automatically when the next machine phase begins
// - Add: bit 11 picks A or B, sum with memory data stored there
// - Compare: XOR accumulator with data, not stored, nonzero sets carry
// - Load: memory word copied into A or B at T3-T4
// - Store: drop read word, accumulator into data register at T1-T2, then written
// - Register-reference done in fetch phase; low bits select T3-T5 work; P advances
// - Shifts and rotates at T3, T5 or both; extend clear and LSB skip at T4
// - Left shift keeping sign: bits 0-13 up, bit 15 kept, zero into bit 0
// - Arithmetic right shift: bits 1-15 down, bit 15 kept
// - Rotate left feeds bit 15 to bit 0; rotate right feeds bit 0 to bit 15
// - Left shift clearing sign: bits 0-13 to 1-14, bits 0 and 15 zero
// - Rotate right through extend: extend into bit 15, old bit 0 into extend
// - Rotate left through extend: extend into bit 0, old bit 15 into extend
// - Four-place rotate left of whole accumulator
// - At T4 instruction bit 5 set clears extend
// - At T4 bit 3 set tests accumulator LSB; zero sets carry
// - Execute entered after address word with bit 15 zero
`ifndef MCX_DEFS_VH
`define MCX_DEFS_VH
`define MCX_REG_CTRL 4'h0
`define MCX_REG_INSTR 4'h1
`define MCX_REG_ADDRW 4'h2
`define MCX_REG_ACCA 4'h3
`define MCX_REG_ACCB 4'h4
`define MCX_REG_PC 4'h5
`define MCX_REG_MAR 4'h6
`define MCX_REG_MDR 4'h7
`define MCX_BIT_ACCSEL 11
`define MCX_BIT_INDIRECT 15
`define MCX_BIT_CLR_EXT 5
`define MCX_BIT_SKIP_LSB 3
`define MCX_BIT_SH1_EN 9
`define MCX_BIT_SH2_EN 4
`define MCX_OP_AND 3'h1
`define MCX_OP_JSB 4'h3
`define MCX_OP_XOR 4'h4
`define MCX_OP_JMP 4'h5
`define MCX_OP_IOR 4'h6
`define MCX_OP_ISZ 4'h7
`define MCX_OP_ADD 3'h4
`define MCX_OP_CMP 3'h5
`define MCX_OP_LOAD 3'h6
`define MCX_OP_STORE 3'h7
`define MCX_SH_LEFT_KEEP 3'h0
`define MCX_SH_ARITH_RIGHT 3'h1
`define MCX_SH_ROT_LEFT 3'h2
`define MCX_SH_ROT_RIGHT 3'h3
`define MCX_SH_LEFT_CLEAR 3'h4
`define MCX_SH_EXT_RIGHT 3'h5
`define MCX_SH_EXT_LEFT 3'h6
`define MCX_SH_ROT_FOUR 3'h7
`define MCX_RESET_WORD 16'h0000
`define MCX_RESET_ADDR 15'h0000
`endif

// ### hw/mcx_datapath.v
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "mcx_defs.vh"
module mcx_datapath (
    // Clock and reset
    input wire CLK,
    input wire RESET,
    // Register port
    input wire [3:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [15:0] RDATA,
    // Core memory
    output reg [14:0] MEM_ADDR,
    output reg MEM_RD,
    input wire [15:0] MEM_RDATA,
    output reg MEM_WR,
    output reg [15:0] MEM_WDATA,
    // Status
    output reg BUSY,
    output reg DONE
);
    localparam [10:0] ST_IDLE = 11'h001;
    localparam [10:0] ST_T0 = 11'h002;
    localparam [10:0] ST_T1 = 11'h004;
    localparam [10:0] ST_T2 = 11'h008;
    localparam [10:0] ST_T3 = 11'h010;
    localparam [10:0] ST_T4 = 11'h020;
    localparam [10:0] ST_T5 = 11'h040;
    localparam [10:0] ST_TW1 = 11'h080;
    localparam [10:0] ST_TW2 = 11'h100;
    localparam [10:0] ST_T6 = 11'h200;
    localparam [10:0] ST_T7 = 11'h400;

    reg [10:0] state_r;
    reg [15:0] ir_r;
    reg [15:0] acc_a_r;
    reg [15:0] acc_b_r;
    reg [14:0] pc_r;
    reg [14:0] mar_r;
    reg [15:0] mdr_r;
    reg ext_r;
    reg carry_r;
    reg exec_r;
    reg indirect_r;

    wire [3:0] opcode = ir_r[14:11];
    wire [2:0] opgrp = ir_r[14:12];
    wire acc_sel = ir_r[`MCX_BIT_ACCSEL];
    wire [15:0] acc_cur = acc_sel ? acc_b_r : acc_a_r;
    wire is_memref = (opgrp != 3'h0);
    wire is_isz = exec_r && (opcode == `MCX_OP_ISZ);
    wire is_jsb = exec_r && (opcode == `MCX_OP_JSB);
    wire is_store = exec_r && (opgrp == `MCX_OP_STORE);
    wire is_shift_grp = (ir_r[15:12] == 4'h0) && !ir_r[10];
    wire [16:0] mdr_inc = {1'b0, mdr_r} + 17'h00001;
    wire [14:0] pc_inc = pc_r + {14'h0000, 1'b1} + {14'h0000, carry_r};

    // Shift network; result bit 16 is the new extend value
    function [16:0] mcx_shift;
        input [2:0] code;
        input [15:0] v;
        input e;
        begin
            case (code)
                `MCX_SH_LEFT_KEEP: mcx_shift = {e, v[15], v[13:0], 1'b0};
                `MCX_SH_ARITH_RIGHT: mcx_shift = {e, v[15], v[15:1]};
                `MCX_SH_ROT_LEFT: mcx_shift = {e, v[14:0], v[15]};
                `MCX_SH_ROT_RIGHT: mcx_shift = {e, v[0], v[15:1]};
                `MCX_SH_LEFT_CLEAR: mcx_shift = {e, 1'b0, v[13:0], 1'b0};
                `MCX_SH_EXT_RIGHT: mcx_shift = {v[0], e, v[15:1]};
                `MCX_SH_EXT_LEFT: mcx_shift = {v[15], v[14:0], e};
                default: mcx_shift = {e, v[11:0], v[15:12]};
            endcase
        end
    endfunction

    // Shift stage for the current period; T3 uses the first code, T5 the second
    reg sh_en;
    reg [2:0] sh_code;
    reg [16:0] sh_res;
    always @* begin
        sh_en = 1'b0;
        sh_code = ir_r[8:6];
        if (!exec_r && is_shift_grp) begin
            if (state_r == ST_T3) begin
                sh_en = ir_r[`MCX_BIT_SH1_EN];
            end else if (state_r == ST_T5) begin
                sh_en = ir_r[`MCX_BIT_SH2_EN];
                sh_code = ir_r[2:0];
            end
        end
        sh_res = mcx_shift(sh_code, acc_cur, ext_r);
    end

    // Execute-phase result at T3
    reg wr_acc;
    reg [15:0] alu_res;
    always @* begin
        wr_acc = 1'b0;
        alu_res = mdr_r;
        if (opcode == `MCX_OP_XOR) begin
            wr_acc = 1'b1;
            alu_res = acc_a_r ^ mdr_r;
        end else if (opcode == `MCX_OP_IOR) begin
            wr_acc = 1'b1;
            alu_res = acc_a_r | mdr_r;
        end else if (opgrp == `MCX_OP_AND && !ir_r[11]) begin
            wr_acc = 1'b1;
            alu_res = acc_a_r & mdr_r;
        end else if (opgrp == `MCX_OP_ADD) begin
            wr_acc = 1'b1;
            alu_res = acc_cur + mdr_r;
        end else if (opgrp == `MCX_OP_LOAD) begin
            wr_acc = 1'b1;
            alu_res = mdr_r;
        end
    end

    // XOR/INCLUSIVE_OR_TO_ACC/AND always target A; the others follow bit 11
    wire alu_to_b = acc_sel && (opgrp == `MCX_OP_ADD || opgrp == `MCX_OP_LOAD);

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state_r <= ST_IDLE;
            ir_r <= `MCX_RESET_WORD;
            acc_a_r <= `MCX_RESET_WORD;
            acc_b_r <= `MCX_RESET_WORD;
            pc_r <= `MCX_RESET_ADDR;
            mar_r <= `MCX_RESET_ADDR;
            mdr_r <= `MCX_RESET_WORD;
            ext_r <= 1'b0;
            carry_r <= 1'b0;
            exec_r <= 1'b0;
            indirect_r <= 1'b0;
            MEM_ADDR <= `MCX_RESET_ADDR;
            MEM_RD <= 1'b0;
            MEM_WR <= 1'b0;
            MEM_WDATA <= `MCX_RESET_WORD;
            BUSY <= 1'b0;
            DONE <= 1'b0;
        end else begin
            MEM_RD <= 1'b0;
            MEM_WR <= 1'b0;
            DONE <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    // Registers are only written while no instruction runs
                    if (WR) begin
                        case (ADDR)
                            `MCX_REG_CTRL: ext_r <= WDATA[0];
                            `MCX_REG_INSTR: begin
                                ir_r <= WDATA;
                                indirect_r <= 1'b0;
                                if (WDATA[15:12] == 4'h0 && !WDATA[10]) begin
                                    exec_r <= 1'b0;
                                    carry_r <= 1'b0;
                                    BUSY <= 1'b1;
                                    state_r <= ST_T0;
                                end
                            end
                            `MCX_REG_ADDRW: begin
                                if (is_memref && opcode != `MCX_OP_JMP) begin
                                    mar_r <= WDATA[14:0];
                                    if (!WDATA[`MCX_BIT_INDIRECT]) begin
                                        exec_r <= 1'b1;
                                        carry_r <= 1'b0;
                                        indirect_r <= 1'b0;
                                        BUSY <= 1'b1;
                                        state_r <= ST_T0;
                                    end else begin
                                        // Indirect chains are resolved outside
                                        indirect_r <= 1'b1;
                                    end
                                end
                            end
                            `MCX_REG_ACCA: acc_a_r <= WDATA;
                            `MCX_REG_ACCB: acc_b_r <= WDATA;
                            `MCX_REG_PC: pc_r <= WDATA[14:0];
                            default: ;
                        endcase
                    end
                end
                ST_T0: begin
                    if (exec_r) begin
                        mdr_r <= `MCX_RESET_WORD;
                        MEM_ADDR <= mar_r;
                        MEM_RD <= 1'b1;
                    end
                    state_r <= ST_T1;
                end
                ST_T1: begin
                    // The core answers while its read strobe stands, so the word
                    // is taken at the end of T1; a later sample would see the inverted idle bus
                    if (is_jsb) begin
                        mdr_r <= {1'b0, pc_r + 15'h0001};
                    end else if (is_store) begin
                        mdr_r <= acc_cur;
                    end else if (exec_r) begin
                        mdr_r <= MEM_RDATA;
                    end
                    state_r <= ST_T2;
                end
                ST_T2: begin
                    // Core reads destroy the cell, so every plain cycle writes back
                    if (exec_r && !is_isz) begin
                        MEM_WR <= 1'b1;
                        MEM_WDATA <= mdr_r;
                    end
                    state_r <= ST_T3;
                end
                ST_T3: begin
                    if (exec_r) begin
                        if (is_jsb) begin
                            pc_r <= mar_r;
                        end else if (is_isz) begin
                            mdr_r <= mdr_inc[15:0];
                            if (mdr_inc[16]) begin
                                carry_r <= 1'b1;
                            end
                        end else if (opgrp == `MCX_OP_CMP) begin
                            if ((acc_cur ^ mdr_r) != 16'h0000) begin
                                carry_r <= 1'b1;
                            end
                        end else if (wr_acc) begin
                            if (alu_to_b) begin
                                acc_b_r <= alu_res;
                            end else begin
                                acc_a_r <= alu_res;
                            end
                        end
                    end else if (sh_en) begin
                        ext_r <= sh_res[16];
                        if (acc_sel) begin
                            acc_b_r <= sh_res[15:0];
                        end else begin
                            acc_a_r <= sh_res[15:0];
                        end
                    end
                    state_r <= ST_T4;
                end
                ST_T4: begin
                    if (is_isz) begin
                        MEM_WR <= 1'b1;
                        MEM_WDATA <= mdr_r;
                    end
                    if (!exec_r && is_shift_grp) begin
                        if (ir_r[`MCX_BIT_CLR_EXT]) begin
                            ext_r <= 1'b0;
                        end
                        if (ir_r[`MCX_BIT_SKIP_LSB] && !acc_cur[0]) begin
                            carry_r <= 1'b1;
                        end
                    end
                    state_r <= ST_T5;
                end
                ST_T5: begin
                    if (sh_en) begin
                        ext_r <= sh_res[16];
                        if (acc_sel) begin
                            acc_b_r <= sh_res[15:0];
                        end else begin
                            acc_a_r <= sh_res[15:0];
                        end
                    end
                    state_r <= is_isz ? ST_TW1 : ST_T6;
                end
                // Two spare periods let the core finish the late write
                ST_TW1: state_r <= ST_TW2;
                ST_TW2: state_r <= ST_T6;
                ST_T6: begin
                    // Carry stands only for skips, so a plain step adds one
                    pc_r <= pc_inc;
                    mar_r <= pc_inc;
                    state_r <= ST_T7;
                end
                ST_T7: begin
                    exec_r <= 1'b0;
                    BUSY <= 1'b0;
                    DONE <= 1'b1;
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            RDATA <= `MCX_RESET_WORD;
        end else if (RD) begin
            case (ADDR)
                `MCX_REG_CTRL: RDATA <= {11'h000, indirect_r, exec_r, carry_r, BUSY, ext_r};
                `MCX_REG_INSTR: RDATA <= ir_r;
                `MCX_REG_ACCA: RDATA <= acc_a_r;
                `MCX_REG_ACCB: RDATA <= acc_b_r;
                `MCX_REG_PC: RDATA <= {1'b0, pc_r};
                `MCX_REG_MAR: RDATA <= {1'b0, mar_r};
                `MCX_REG_MDR: RDATA <= mdr_r;
                default: RDATA <= `MCX_RESET_WORD;
            endcase
        end else begin
            RDATA <= `MCX_RESET_WORD;
        end
    end
endmodule
`default_nettype wire

// ### sim/mcx_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module mcx_mem_model (
    // Clock
    input wire logic clk,
    // Core port
    input wire logic [14:0] mem_addr,
    input wire logic mem_rd,
    output logic [15:0] mem_rdata,
    input wire logic mem_wr,
    input wire logic [15:0] mem_wdata
);
    logic [15:0] mem [0:32767];
    // Word stands while the read strobe does; the idle bus shows its inverse
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
    always @(posedge clk) begin
        if (mem_wr)
            mem[mem_addr] <= mem_wdata;
    end
endmodule
`default_nettype wire

// ### sim/mcx_datapath_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "mcx_defs.vh"
module mcx_datapath_props (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    // Core memory
    input wire logic [14:0] MEM_ADDR,
    input wire logic MEM_RD,
    input wire logic [15:0] MEM_RDATA,
    input wire logic MEM_WR,
    input wire logic [15:0] MEM_WDATA,
    // Status
    input wire logic BUSY,
    input wire logic DONE
);
    default clocking dc @(posedge CLK); endclocking
    default disable iff (RESET);
    // Long phases are measured by a counter; a long repetition unrolls too far
    logic [4:0] busy_len_r;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET)
            busy_len_r <= 5'h00;
        else if (BUSY)
            busy_len_r <= busy_len_r + 5'h01;
        else
            busy_len_r <= 5'h00;
    end
    a_read_opens_phase: assert property (MEM_RD |-> BUSY && !$past(BUSY, 2))
        else $error("core read not in first period");
    a_write_slot: assert property (MEM_RD |-> (##2 MEM_WR) or (##4 MEM_WR))
        else $error("core write missing after read");
    a_write_cause: assert property (MEM_WR |-> $past(MEM_RD, 2) || $past(MEM_RD, 4))
        else $error("core write without read");
    a_addr_held: assert property (MEM_RD |=> $stable(MEM_ADDR)[*5])
        else $error("core address moved in cycle");
    a_phase_length: assert property ($fell(BUSY) |->
        (busy_len_r == 5'h08 || busy_len_r == 5'h0A))
        else $error("phase length wrong");
    a_busy_bound: assert property (busy_len_r <= 5'h0A)
        else $error("phase runs too long");
    a_done_ends: assert property (DONE == $fell(BUSY))
        else $error("done not right after phase");
    a_std_tail: assert property ((MEM_RD ##2 MEM_WR) |=> BUSY[*4] ##1 DONE)
        else $error("tail after write wrong");
    a_isz_tail: assert property ((MEM_RD ##4 MEM_WR) |=> BUSY[*4] ##1 DONE)
        else $error("tail after late write wrong");
    a_regref_quiet: assert property ((WR && !BUSY && ADDR == `MCX_REG_INSTR &&
        WDATA[15:12] == 4'h0 && !WDATA[10]) |=> (!MEM_RD && !MEM_WR)[*8])
        else $error("memory used by register op");
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("read data outside slot");
endmodule
bind mcx_datapath mcx_datapath_props mcx_datapath_props_i (
    .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA),
    .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA), .BUSY(BUSY), .DONE(DONE)
);
`default_nettype wire

// ### sim/tb_mcx_datapath.sv
`timescale 1ns/10ps
`default_nettype none
module tb_mcx_datapath;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic [3:0] ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0000;
    logic WR = 1'b0;
    logic RD = 1'b0;
    wire [15:0] RDATA, MEM_RDATA, MEM_WDATA;
    wire [14:0] MEM_ADDR;
    wire MEM_RD, MEM_WR, BUSY, DONE;
    int errors = 0;
    int check_count = 0;
    logic [31:0] seed = 32'h40EC6A9A;
    logic [3:0] ops [13] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB,
        4'hC, 4'hD, 4'hE, 4'hF};
    mcx_datapath mcx_datapath_i (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
        .MEM_RDATA(MEM_RDATA), .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA),
        .BUSY(BUSY), .DONE(DONE));
    mcx_mem_model mcx_mem_model_i (.clk(CLK), .mem_addr(MEM_ADDR), .mem_rd(MEM_RD),
        .mem_rdata(MEM_RDATA), .mem_wr(MEM_WR), .mem_wdata(MEM_WDATA));
    always #5 CLK = ~CLK;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Result is {extend, accumulator}
    function automatic logic [16:0] shf(input logic [2:0] c, input logic [15:0] v,
        input logic e);
        case (c)
            3'h0: shf = {e, v[15], v[13:0], 1'b0};
            3'h1: shf = {e, v[15], v[15:1]};
            3'h2: shf = {e, v[14:0], v[15]};
            3'h3: shf = {e, v[0], v[15:1]};
            3'h4: shf = {e, 1'b0, v[13:0], 1'b0};
            3'h5: shf = {v[0], e, v[15:1]};
            3'h6: shf = {v[15], v[14:0], e};
            default: shf = {e, v[11:0], v[15:12]};
        endcase
    endfunction
    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    task automatic wait_done();
        repeat (40) begin
            @(posedge CLK);
            #1;
            if (DONE === 1'b1)
                return;
        end
        errors++;
        $display("Error t=%0t got %h exp %h", $time, DONE, 1'b1);
        tally_and_finish();
    endtask
    initial begin
        logic [15:0] a, b, p, w, x, v, ins;
        logic [16:0] s;
        logic [31:0] r;
        logic [3:0] op;
        logic [14:0] m;
        logic e, k;
        repeat (5) @(posedge CLK);
        RESET <= 1'b0;
        for (int i = 0; i < 9; i++)
            rc(i[3:0], 16'h0000);
        wr(4'hF, 16'hFFFF);
        rc(4'hF, 16'h0000);
        for (int i = 0; i < 48; i++) begin
            r = rnd();
            ins = {4'h0, r[11], 1'b0, r[9:0]};
            r = rnd();
            v = r[15:0];
            p = {4'h0, r[27:16]};
            e = r[31];
            wr(4'h3, ins[11] ? ~v : v);
            wr(4'h4, ins[11] ? v : ~v);
            wr(4'h0, {15'h0000, e});
            wr(4'h5, p);
            s = {e, v};
            if (ins[9])
                s = shf(ins[8:6], s[15:0], s[16]);
            k = ins[3] && !s[0];
            if (ins[5])
                s[16] = 1'b0;
            if (ins[4])
                s = shf(ins[2:0], s[15:0], s[16]);
            wr(4'h1, ins);
            wait_done();
            rc(4'h3, ins[11] ? ~v : s[15:0]);
            rc(4'h4, ins[11] ? s[15:0] : ~v);
            rd(4'h0, x);
            chk({15'h0000, x[0]}, {15'h0000, s[16]});
            p = p + 16'h0001 + {15'h0000, k};
            rc(4'h5, p);
            rc(4'h6, {1'b0, p[14:0]});
        end
        for (int i = 0; i < 52; i++) begin
            op = ops[i % 13];
            r = rnd();
            a = r[15:0];
            b = r[31:16];
            r = rnd();
            w = r[15:0];
            p = {4'h0, r[27:16]};
            r = rnd();
            m = r[14:0];
            // Last 26 passes hit rollover and equal compare
            if (i >= 26)
                w = (op == 4'h7) ? 16'hFFFF : (op[0] ? b : a);
            wr(4'h3, a);
            wr(4'h4, b);
            wr(4'h5, p);
            mcx_mem_model_i.mem[m] = w;
            wr(4'h1, {1'b0, op, 11'h000});
            if (r[15]) begin
                wr(4'h2, {1'b1, m});
                rd(4'h0, x);
                chk({15'h0000, BUSY}, 16'h0000);
                chk({15'h0000, x[4]}, 16'h0001);
            end
            wr(4'h2, {1'b0, m});
            wr(4'h3, ~a);
            wait_done();
            x = w;
            k = 1'b0;
            case (op)
                4'h2: a = a & w;
                4'h3: begin
                    x = p + 16'h0001;
                    p = {1'b0, m};
                end
                4'h4: a = a ^ w;
                4'h6: a = a | w;
                4'h7: begin
                    x = w + 16'h0001;
                    k = (w == 16'hFFFF);
                end
                4'h8: a = a + w;
                4'h9: b = b + w;
                4'hA, 4'hB: k = ((op[0] ? b : a) != w);
                4'hC: a = w;
                4'hD: b = w;
                default: x = op[0] ? b : a;
            endcase
            p = p + 16'h0001 + {15'h0000, k};
            rc(4'h3, a);
            rc(4'h4, b);
            rc(4'h5, {1'b0, p[14:0]});
            rc(4'h6, {1'b0, p[14:0]});
            chk(mcx_mem_model_i.mem[m], x);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
